// [common/rix_consts.svh]
`ifndef RIX_CONSTS_SVH
`define RIX_CONSTS_SVH

// ****************************************
// Register offsets
// ****************************************
`define RIX_A_INSTR   8'h00
`define RIX_A_STAT    8'h04
`define RIX_A_PC_LO   8'h08
`define RIX_A_PC_HI   8'h0c
`define RIX_A_MEM_LO  8'h10
`define RIX_A_MEM_HI  8'h14
`define RIX_A_EA_LO   8'h18
`define RIX_A_EA_HI   8'h1c
`define RIX_A_RSEL    8'h20
`define RIX_A_RDAT_LO 8'h24
`define RIX_A_RDAT_HI 8'h28
`define RIX_A_CTRL    8'h2c
`define RIX_A_LIBFN   8'h30
`define RIX_A_FCTL    8'h34

// ****************************************
// Opcodes and functions
// ****************************************
`define RIX_OP_PRIVILEGED_LIBRARY_CALL 6'h00
`define RIX_OP_INT   6'h10
`define RIX_OP_FLT   6'h16
`define RIX_OP_JMP   6'h1a
`define RIX_OP_BR    6'h30
`define RIX_OPG_MEM  2'h2
`define RIX_OPG_ICB  3'h7
`define RIX_OPG_FCB  3'h6
`define RIX_F_ADD    5'h00
`define RIX_F_SUB    5'h09
`define RIX_F_MUL    5'h0c
`define RIX_FB_QUAD  5
`define RIX_FB_CHK   6
`define RIX_F_UNCHECKED_QUAD_ADD 7'h20
`define RIX_F_CHECKED_QUAD_ADD   7'h60
`define RIX_FF_CPYS  6'h20
`define RIX_FF_CPYSN 6'h21
`define RIX_FF_CPYSE 6'h22
`define RIX_LIB_BASE 64'h0000_0000_0000_8000
`define RIX_INTEGER_ZERO_REGISTER 6'h1f
`define RIX_FLOAT_ZERO_REGISTER   6'h3f
`define RIX_RST_PC   64'h0
`define RIX_RST_KERN 1'h1
`endif

// [common/rix_pkg.sv]
package rix_pkg;
  typedef struct packed {
    logic [5:0] op;
    logic [4:0] ra;
    logic [4:0] rb;
    logic [2:0] must_be_zero_field;
    logic       lit_en;
    logic [6:0] func;
    logic [4:0] rc;
  } rix_op_t;
  typedef struct packed {
    logic halted;
    logic taken;
    logic unalign;
    logic ovf;
    logic illegal;
  } rix_stat_t;
  typedef struct packed {
    logic [2:0] trap_en;
    logic [1:0] rnd;
  } rix_fctl_t;
  typedef enum logic {
    ST_RUN  = 1'b0,
    ST_HALT = 1'b1
  } rix_state_t;
endpackage : rix_pkg

// [design/rix_core.sv]
`timescale 1ns/1ps
`default_nettype none
`include "rix_consts.svh"
module rix_core (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic               pready,
  output logic [31:0]        prdata,
  output logic               pslverr,
  output var rix_pkg::rix_stat_t status
);
  import rix_pkg::*;

  function automatic logic [63:0] sx32(input logic [31:0] v);
    sx32 = {{32{v[31]}}, v};
  endfunction : sx32

  function automatic logic [63:0] wswap(input logic [63:0] v);
    wswap = {v[15:0], v[31:16], v[47:32], v[63:48]};
  endfunction : wswap

  // ****************************************
  // APB slave
  // ****************************************
  logic        pready_q;
  logic [31:0] prdata_q;
  logic        pslverr_q;
  logic        acc;
  logic        wr_go;
  logic        rd_cap;
  logic        mapped;
  logic [31:0] rd_mux;
  logic s_instr, s_stat, s_pclo, s_pchi, s_mlo, s_mhi, s_ealo;
  logic s_eahi, s_rsel, s_rdlo, s_rdhi, s_ctrl, s_lib, s_fctl;

  assign acc     = psel & penable;
  assign wr_go   = acc & pready_q & pwrite;
  assign rd_cap  = acc & ~pready_q & ~pwrite;
  assign s_instr = paddr == `RIX_A_INSTR;
  assign s_stat  = paddr == `RIX_A_STAT;
  assign s_pclo  = paddr == `RIX_A_PC_LO;
  assign s_pchi  = paddr == `RIX_A_PC_HI;
  assign s_mlo   = paddr == `RIX_A_MEM_LO;
  assign s_mhi   = paddr == `RIX_A_MEM_HI;
  assign s_ealo  = paddr == `RIX_A_EA_LO;
  assign s_eahi  = paddr == `RIX_A_EA_HI;
  assign s_rsel  = paddr == `RIX_A_RSEL;
  assign s_rdlo  = paddr == `RIX_A_RDAT_LO;
  assign s_rdhi  = paddr == `RIX_A_RDAT_HI;
  assign s_ctrl  = paddr == `RIX_A_CTRL;
  assign s_lib   = paddr == `RIX_A_LIBFN;
  assign s_fctl  = paddr == `RIX_A_FCTL;
  assign mapped  = s_instr | s_stat | s_pclo | s_pchi | s_mlo | s_mhi
                 | s_ealo | s_eahi | s_rsel | s_rdlo | s_rdhi | s_ctrl
                 | s_lib | s_fctl;

  // One wait state keeps every bus output on a flip-flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= acc & ~pready_q;
      pslverr_q <= acc & ~pready_q & ~mapped;
      if (rd_cap) begin
        prdata_q <= rd_mux;
      end
    end
  end

  // ****************************************
  // Architectural state
  // ****************************************
  logic [63:0] pc_q;
  logic [63:0] md_q;
  logic [63:0] ea_q;
  logic [5:0]  rsel_q;
  logic [31:0] hi_q;
  logic        kern_q;
  logic [7:0]  lib_q;
  rix_fctl_t   fctl_q;
  rix_stat_t   stat_q;
  rix_state_t  state_q;
  rix_state_t  state_d;
  logic [63:0] ireg [0:31];
  logic [63:0] freg [0:31];

  // ****************************************
  // Instruction decode
  // ****************************************
  rix_op_t     ins;
  logic        exec;
  logic        is_lib, is_int, is_flt, is_jmp, is_br;
  logic        is_mem, is_icb, is_fcb;
  logic        m_int, m_st, m_q;
  logic [2:0]  cc;
  logic [63:0] ra_i, rb_i, ra_f, rb_f;

  // Halted core ignores instruction writes until the PC is reloaded
  assign exec   = wr_go & s_instr & (state_q == ST_RUN);
  assign ins    = rix_op_t'(pwdata);
  assign is_lib = ins.op == `RIX_OP_PRIVILEGED_LIBRARY_CALL;
  assign is_int = ins.op == `RIX_OP_INT;
  assign is_flt = ins.op == `RIX_OP_FLT;
  assign is_jmp = ins.op == `RIX_OP_JMP;
  assign is_br  = ins.op == `RIX_OP_BR;
  assign is_mem = (ins.op[5:4] == `RIX_OPG_MEM) & ~ins.op[1];
  assign is_icb = ins.op[5:3] == `RIX_OPG_ICB;
  // Parity tests exist only for integer registers
  assign is_fcb = (ins.op[5:3] == `RIX_OPG_FCB)
                & (ins.op[1:0] != 2'h0);
  // Width comes from the opcode bits alone
  assign m_int  = ins.op[3];
  assign m_st   = ins.op[2];
  assign m_q    = ins.op[0];
  assign cc     = ins.op[2:0];
  assign ra_i   = ireg[ins.ra];
  assign rb_i   = ireg[ins.rb];
  assign ra_f   = freg[ins.ra];
  assign rb_f   = freg[ins.rb];

  // ****************************************
  // Integer operate
  // ****************************************
  logic [4:0]   fb;
  logic         quad;
  logic         chk;
  logic         int_ok;
  logic [63:0]  bv;
  logic [63:0]  oa;
  logic [63:0]  ob;
  logic [63:0]  sum;
  logic [63:0]  dif;
  logic [127:0] prod;
  logic [63:0]  raw;
  logic [63:0]  alu;
  logic         ov_add, ov_sub, ov_mul, ov_long, ov_raw;

  assign fb     = ins.func[4:0];
  assign quad   = ins.func[`RIX_FB_QUAD];
  assign chk    = ins.func[`RIX_FB_CHK];
  assign int_ok = is_int & ((fb == `RIX_F_ADD) | (fb == `RIX_F_SUB)
                | (fb == `RIX_F_MUL));
  assign bv     = ins.lit_en ? {56'h0, ins.rb, ins.must_be_zero_field}
                : rb_i;
  assign oa     = quad ? ra_i : sx32(ra_i[31:0]);
  assign ob     = quad ? bv : sx32(bv[31:0]);
  assign sum    = oa + ob;
  assign dif    = oa - ob;
  assign prod   = $signed(oa) * $signed(ob);
  assign raw    = (fb == `RIX_F_ADD) ? sum
                : (fb == `RIX_F_SUB) ? dif : prod[63:0];
  assign alu    = quad ? raw : sx32(raw[31:0]);
  assign ov_add = (oa[63] == ob[63]) & (sum[63] != oa[63]);
  assign ov_sub = (oa[63] != ob[63]) & (dif[63] != oa[63]);
  assign ov_mul = prod[127:64] != {64{prod[63]}};
  // Long results overflow when they leave the canonical form
  assign ov_long = raw != sx32(raw[31:0]);
  assign ov_raw = ~quad ? ov_long
                : (fb == `RIX_F_ADD) ? ov_add
                : (fb == `RIX_F_SUB) ? ov_sub : ov_mul;

  // ****************************************
  // Floating operate
  // ****************************************
  logic [10:0] fn;
  logic [5:0]  fop;
  logic        flt_ok;
  logic [63:0] fres;

  assign fn     = pwdata[15:5];
  assign fop    = fn[5:0];
  assign flt_ok = is_flt & ((fop == `RIX_FF_CPYS)
                | (fop == `RIX_FF_CPYSN) | (fop == `RIX_FF_CPYSE));
  assign fres   = (fop == `RIX_FF_CPYS) ? {ra_f[63], rb_f[62:0]}
                : (fop == `RIX_FF_CPYSN) ? {~ra_f[63], rb_f[62:0]}
                : {ra_f[63:52], rb_f[51:0]};

  // ****************************************
  // Load and store
  // ****************************************
  logic [63:0] ea;
  logic        unal;
  logic [7:0]  fx;
  logic [10:0] fexp;
  logic [63:0] ld_f;
  logic [63:0] ld_v;
  logic [63:0] st_src;
  logic [31:0] st_f;
  logic [63:0] st_v;

  assign ea     = rb_i + {{48{pwdata[15]}}, pwdata[15:0]};
  assign unal   = is_mem & (m_q ? (ea[2:0] != 3'h0)
                : (ea[1:0] != 2'h0));
  assign fx     = md_q[14:7];
  // Zero stays zero; otherwise the top bit is copied three times inverted
  assign fexp   = (fx == 8'h0) ? 11'h0
                : {fx[7], {3{~fx[7]}}, fx[6:0]};
  assign ld_f   = {md_q[15], fexp, md_q[6:0], md_q[31:16],
                   29'h0};
  assign ld_v   = m_int ? (m_q ? md_q : sx32(md_q[31:0]))
                : (m_q ? wswap(md_q) : ld_f);
  assign st_src = m_int ? ra_i : ra_f;
  // Exponent bits 61:59 and low fraction are dropped on the way out
  assign st_f   = {st_src[44:29], st_src[63:62], st_src[58:45]};
  assign st_v   = m_int ? (m_q ? st_src : {32'h0, st_src[31:0]})
                : (m_q ? wswap(st_src) : {32'h0, st_f});

  // ****************************************
  // Branches, jumps and library calls
  // ****************************************
  logic [63:0] tv;
  logic        zr;
  logic        ng;
  logic        od;
  logic [7:0]  cond_v;
  logic        take;
  logic [63:0] pc4;
  logic [63:0] btgt;
  logic [63:0] jtgt;
  logic [63:0] libtgt;

  // Decision reads only the register; there are no stored flags
  assign tv     = is_icb ? ra_i : ra_f;
  assign zr     = is_icb ? (tv == 64'h0) : (tv[62:0] == 63'h0);
  assign ng     = tv[63] & ~zr;
  assign od     = tv[0];
  assign cond_v = {~ng & ~zr, ~ng, ~zr, od, ng | zr, ng, zr, ~od};
  assign take   = (is_icb | is_fcb) & cond_v[cc];
  assign pc4    = pc_q + 64'h4;
  assign btgt   = pc4 + {{41{pwdata[20]}}, pwdata[20:0], 2'h0};
  assign jtgt   = {rb_i[63:2], 2'h0};
  assign libtgt = `RIX_LIB_BASE | {50'h0, pwdata[7:0], 6'h0};

  // ****************************************
  // Faults and next state
  // ****************************************
  logic        known;
  logic        undef;
  logic        zf_bad;
  logic        ill;
  logic        halt_go;
  logic        fault;
  logic [63:0] pc_nx;

  assign known   = int_ok | flt_ok | is_lib | is_br | is_jmp | is_mem
                 | is_icb | is_fcb;
  assign undef   = ~known;
  assign zf_bad  = (is_int & ~ins.lit_en
                 & (ins.must_be_zero_field != 3'h0))
                 | (is_lib & (pwdata[25:8] != 18'h0));
  // User mode gets an exception; only kernel mode reaches a halt
  assign ill     = zf_bad | (is_lib & ~pwdata[7] & ~kern_q)
                 | (undef & ~kern_q);
  assign halt_go = undef & kern_q;
  assign fault   = ill | unal | halt_go;
  // Jump hint bits are never looked at, so junk there cannot leak
  assign pc_nx   = fault ? pc_q
                 : (is_br | take) ? btgt
                 : is_jmp ? jtgt
                 : is_lib ? libtgt : pc4;
  assign state_d = (exec & halt_go) ? ST_HALT
                 : (wr_go & s_pclo) ? ST_RUN : state_q;

  // ****************************************
  // Register file write port
  // ****************************************
  logic        x_wen;
  logic        x_fp;
  logic [4:0]  x_idx;
  logic [63:0] x_val;
  logic        wb_en;
  logic        wb_fp;
  logic [4:0]  wb_idx;
  logic [63:0] wb_val;

  assign x_wen  = ~fault & (is_int | is_flt | (is_mem & ~m_st)
                | is_br | is_jmp);
  assign x_fp   = is_flt | (is_mem & ~m_int);
  assign x_idx  = (is_int | is_flt) ? ins.rc : ins.ra;
  assign x_val  = is_int ? alu : is_flt ? fres
                : is_mem ? ld_v : pc4;
  assign wb_en  = (exec & x_wen) | (wr_go & s_rdlo);
  assign wb_fp  = exec ? x_fp : rsel_q[5];
  assign wb_idx = exec ? x_idx : rsel_q[4:0];
  assign wb_val = exec ? x_val : {hi_q, pwdata};

  // Entry 31 of each file is a constant, so writes there vanish
  for (genvar gi = 0; gi < 32; gi++) begin : g_rf
    if (gi == 31) begin : g_zero
      assign ireg[gi] = 64'h0;
      assign freg[gi] = 64'h0;
    end else begin : g_cell
      always_ff @(posedge pclk) begin
        if (wb_en & ~wb_fp & (wb_idx == 5'(gi))) begin
          ireg[gi] <= wb_val;
        end
      end
      always_ff @(posedge pclk) begin
        if (wb_en & wb_fp & (wb_idx == 5'(gi))) begin
          freg[gi] <= wb_val;
        end
      end
    end
  end

  // ****************************************
  // Control and status registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_q <= `RIX_RST_PC;
    end else if (exec) begin
      pc_q <= pc_nx;
    end else if (wr_go & s_pclo) begin
      pc_q[31:0] <= pwdata;
    end else if (wr_go & s_pchi) begin
      pc_q[63:32] <= pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      md_q <= 64'h0;
      ea_q <= 64'h0;
    end else begin
      if (exec & is_mem) begin
        ea_q <= ea;
      end
      if (exec & is_mem & m_st & ~fault) begin
        md_q <= st_v;
      end else if (wr_go & s_mlo) begin
        md_q[31:0] <= pwdata;
      end else if (wr_go & s_mhi) begin
        md_q[63:32] <= pwdata;
      end
    end
  end

  // Unused bits of writable registers are simply not stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsel_q <= 6'h0;
      hi_q   <= 32'h0;
      kern_q <= `RIX_RST_KERN;
    end else if (wr_go) begin
      if (s_rsel) rsel_q <= pwdata[5:0];
      if (s_rdhi) hi_q <= pwdata;
      if (s_ctrl) kern_q <= pwdata[0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lib_q   <= 8'h0;
      fctl_q  <= '0;
      stat_q  <= '0;
      state_q <= ST_RUN;
    end else begin
      state_q       <= state_d;
      stat_q.halted <= state_d == ST_HALT;
      if (exec & is_lib & ~fault) begin
        lib_q <= pwdata[7:0];
      end
      if (exec & flt_ok) begin
        fctl_q <= rix_fctl_t'(fn[10:6]);
      end
      if (exec) begin
        stat_q.illegal <= ill;
        stat_q.ovf     <= is_int & chk & ov_raw & ~fault;
        stat_q.unalign <= unal;
        stat_q.taken   <= ~fault & (is_br | is_jmp | take);
      end
    end
  end

  // ****************************************
  // Read-back
  // ****************************************
  logic [63:0] rv;

  assign rv     = rsel_q[5] ? freg[rsel_q[4:0]] : ireg[rsel_q[4:0]];
  assign rd_mux = s_stat ? {27'h0, stat_q}
                : s_pclo ? pc_q[31:0]
                : s_pchi ? pc_q[63:32]
                : s_mlo  ? md_q[31:0]
                : s_mhi  ? md_q[63:32]
                : s_ealo ? ea_q[31:0]
                : s_eahi ? ea_q[63:32]
                : s_rsel ? {26'h0, rsel_q}
                : s_rdlo ? rv[31:0]
                : s_rdhi ? rv[63:32]
                : s_ctrl ? {31'h0, kern_q}
                : s_lib  ? {24'h0, lib_q}
                : s_fctl ? {27'h0, fctl_q}
                : 32'h0;

  assign pready  = pready_q;
  assign prdata  = prdata_q;
  assign pslverr = pslverr_q;
  assign status  = stat_q;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_rd_sel(logic [5:0] idx);
    rd_cap & (s_rdlo | s_rdhi) & (rsel_q == idx);
  endsequence

  property p_izero;
    s_rd_sel(`RIX_INTEGER_ZERO_REGISTER) |=> prdata_q == 32'h0;
  endproperty
  a_izero: assert property (p_izero)
    else $error("integer zero register read nonzero");

  property p_fzero;
    s_rd_sel(`RIX_FLOAT_ZERO_REGISTER) |=> prdata_q == 32'h0;
  endproperty
  a_fzero: assert property (p_fzero)
    else $error("float zero register read nonzero");

  property p_ldl;
    exec & is_mem & m_int & ~m_st & ~m_q & ~fault
      |-> wb_en && wb_val == {{32{md_q[31]}}, md_q[31:0]};
  endproperty
  a_ldl: assert property (p_ldl)
    else $error("long load not sign extended");

  property p_ldf;
    exec & is_mem & ~m_int & ~m_st & ~m_q & ~fault
      |-> wb_val[28:0] == 29'h0 && wb_fp
          && ((wb_val[62:52] == 11'h0) == (md_q[14:7] == 8'h0));
  endproperty
  a_ldf: assert property (p_ldf)
    else $error("short float load form wrong");

  property p_long;
    exec & int_ok & ~quad |-> alu[63:32] == {32{alu[31]}};
  endproperty
  a_long: assert property (p_long)
    else $error("long result not canonical");

  sequence s_beq_taken;
    exec & is_icb & (cc == 3'h1) & (ra_i == 64'h0) & ~fault;
  endsequence

  property p_beq;
    s_beq_taken |=> stat_q.taken && pc_q == $past(btgt);
  endproperty
  a_beq: assert property (p_beq)
    else $error("zero branch not taken");

  property p_jmp;
    exec & is_jmp & ~fault |=> pc_q == {$past(rb_i[63:2]), 2'h0};
  endproperty
  a_jmp: assert property (p_jmp)
    else $error("jump target wrong");

  property p_align;
    exec & unal |=> stat_q.unalign && pc_q == $past(pc_q)
                    && md_q == $past(md_q);
  endproperty
  a_align: assert property (p_align)
    else $error("unaligned access not refused");

  property p_ovf;
    exec & int_ok & ~fault & ov_raw |=> stat_q.ovf == $past(chk);
  endproperty
  a_ovf: assert property (p_ovf)
    else $error("overflow flag ignores enable");

  property p_zero_fld;
    exec & is_int & ~ins.lit_en & (ins.must_be_zero_field != 3'h0)
      |=> stat_q.illegal && pc_q == $past(pc_q);
  endproperty
  a_zero_fld: assert property (p_zero_fld)
    else $error("must-be-zero field not trapped");

  property p_user_undef;
    exec & undef & ~kern_q |=> state_q == ST_RUN && stat_q.illegal;
  endproperty
  a_user_undef: assert property (p_user_undef)
    else $error("user reached an undefined halt");

  property p_resume;
    state_q == ST_HALT & wr_go & s_pclo
      |=> state_q == ST_RUN ##1 !stat_q.halted;
  endproperty
  a_resume: assert property (p_resume)
    else $error("halt not left on program counter load");

  property p_fctl;
    exec & flt_ok |=> fctl_q == $past(pwdata[15:11]);
  endproperty
  a_fctl: assert property (p_fctl)
    else $error("float control not from instruction");
endmodule : rix_core
`default_nettype wire

// [sim/rix_mem_model.sv]
`timescale 1ns/1ps
`default_nettype none
module rix_mem_model (
  input  wire logic [63:0] addr,
  output logic      [63:0] rdata
);
  // Data is a pattern of the low 32 address bits, so stale data from another low word never passes as fresh
  assign rdata = {~addr[31:0], addr[31:0] | 32'h8000_0000};
endmodule : rix_mem_model
`default_nettype wire

// [sim/rix_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "rix_consts.svh"
`define CHK(a, b) begin \
  check_count++; \
  if ((a) !== (b)) begin \
    num_errors++; \
    $display("mismatch at %0t: got %h want %h", $time, (a), (b)); \
  end \
end
module risc_instruction_semantics_tb_top;
  import rix_pkg::*;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  rix_stat_t   status;
  logic [63:0] ea;
  logic [63:0] mem_data;
  logic [31:0] r;
  logic        e;
  logic [7:0]  mask;
  int          num_errors;
  int          check_count;

  rix_core u_dut (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .pready  (pready),
    .prdata  (prdata),
    .pslverr (pslverr),
    .status  (status)
  );
  rix_mem_model u_mem (
    .addr  (ea),
    .rdata (mem_data)
  );

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // ****************************************
  // Bus tasks
  // ****************************************
  task automatic close_out();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out

  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      num_errors++;
      $display("mismatch at %0t: no pready", $time);
      close_out();
    end
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] want);
    xfer(1'b0, a, 32'h0);
    `CHK(r, want)
  endtask : rd_chk

  task automatic chk64(input logic [7:0] a, input logic [63:0] want);
    logic [31:0] lo;
    xfer(1'b0, a, 32'h0);
    lo = r;
    xfer(1'b0, a + 8'h04, 32'h0);
    `CHK({r, lo}, want)
  endtask : chk64

  task automatic set_reg(input logic [5:0] s, input logic [63:0] v);
    wr(`RIX_A_RSEL, {26'h0, s});
    wr(`RIX_A_RDAT_HI, v[63:32]);
    wr(`RIX_A_RDAT_LO, v[31:0]);
  endtask : set_reg

  task automatic chk_reg(input logic [5:0] s, input logic [63:0] want);
    wr(`RIX_A_RSEL, {26'h0, s});
    chk64(`RIX_A_RDAT_LO, want);
  endtask : chk_reg

  // Literal form; the literal's low three bits fill the must-be-zero field
  function automatic logic [31:0] iop(input logic [4:0] ra,
      input logic [7:0] lit, input logic [6:0] fn, input logic [4:0] rc);
    return {`RIX_OP_INT, ra, lit, 1'b1, fn, rc};
  endfunction : iop

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ea = 64'h0;
    num_errors = 0;
    check_count = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(`RIX_A_STAT, 32'h0);
    rd_chk(`RIX_A_CTRL, 32'h1);
    xfer(1'b0, 8'h3c, 32'h0);
    `CHK(e, 1'b1)
    `CHK(r, 32'h0)
    $display("test reset done");
    set_reg(`RIX_INTEGER_ZERO_REGISTER, 64'h1234);
    chk_reg(`RIX_INTEGER_ZERO_REGISTER, 64'h0);
    set_reg(`RIX_FLOAT_ZERO_REGISTER, 64'h5678);
    chk_reg(`RIX_FLOAT_ZERO_REGISTER, 64'h0);
    set_reg(6'h01, 64'h7fff_ffff);
    wr(`RIX_A_INSTR, iop(5'd1, 8'h01, 7'h00, 5'd2));
    chk_reg(6'h02, 64'hffff_ffff_8000_0000);
    wr(`RIX_A_INSTR, iop(5'd31, 8'h01, 7'h09, 5'd3));
    chk_reg(6'h03, 64'hffff_ffff_ffff_ffff);
    wr(`RIX_A_INSTR, iop(5'd1, 8'h02, 7'h0c, 5'd3));
    chk_reg(6'h03, 64'hffff_ffff_ffff_fffe);
    set_reg(6'h04, 64'h7fff_ffff_ffff_ffff);
    wr(`RIX_A_INSTR, iop(5'd4, 8'h01, `RIX_F_CHECKED_QUAD_ADD, 5'd5));
    rd_chk(`RIX_A_STAT, 32'h2);
    wr(`RIX_A_INSTR, iop(5'd4, 8'h01, `RIX_F_UNCHECKED_QUAD_ADD, 5'd5));
    rd_chk(`RIX_A_STAT, 32'h0);
    chk_reg(6'h05, 64'h8000_0000_0000_0000);
    wr(`RIX_A_INSTR, {`RIX_OP_INT, 10'h21, 3'h5, 1'b0, 7'h20, 5'd2});
    rd_chk(`RIX_A_STAT, 32'h1);
    chk_reg(6'h02, 64'hffff_ffff_8000_0000);
    $display("test arithmetic done");
    wr(`RIX_A_PC_LO, 32'h100);
    wr(`RIX_A_PC_HI, 32'h0);
    wr(`RIX_A_INSTR, {`RIX_OP_BR, 5'd7, 21'd3});
    rd_chk(`RIX_A_STAT, 32'h8);
    chk64(`RIX_A_PC_LO, 64'h110);
    chk_reg(6'h07, 64'h104);
    set_reg(6'h08, 64'h1_2345_6677);
    wr(`RIX_A_INSTR, {`RIX_OP_JMP, 5'd9, 5'd8, 16'h0});
    chk64(`RIX_A_PC_LO, 64'h1_2345_6674);
    chk_reg(6'h09, 64'h114);
    // Positive odd, then negative even: every test code on each
    for (int j = 1; j < 3; j++) begin
      mask = (j == 1) ? 8'hf0 : 8'h2d;
      for (int k = 0; k < 8; k++) begin
        wr(`RIX_A_INSTR, {3'b111, k[2:0], j[4:0], 21'd1});
        rd_chk(`RIX_A_STAT, {28'h0, mask[k], 3'h0});
      end
    end
    // Float zero register: eq, le, ge taken; lt, ne, gt not
    mask = 8'h4a;
    for (int k = 1; k < 8; k++) begin
      if (k != 4) begin
        wr(`RIX_A_INSTR, {3'b110, k[2:0], 5'd31, 21'd1});
        rd_chk(`RIX_A_STAT, {28'h0, mask[k], 3'h0});
      end
    end
    wr(`RIX_A_INSTR, {3'b111, 3'h1, 5'd31, 21'd1});
    rd_chk(`RIX_A_STAT, 32'h8);
    rd_chk(`RIX_A_INSTR, 32'h0);
    $display("test branch done");
    set_reg(6'h0a, 64'h1000);
    wr(`RIX_A_INSTR, {6'h28, 5'd11, 5'd10, 16'h0002});
    rd_chk(`RIX_A_STAT, 32'h4);
    rd_chk(`RIX_A_EA_LO, 32'h1002);
    ea = 64'h1000;
    #1;
    wr(`RIX_A_MEM_LO, mem_data[31:0]);
    wr(`RIX_A_MEM_HI, mem_data[63:32]);
    wr(`RIX_A_INSTR, {6'h28, 5'd11, 5'd10, 16'h0000});
    chk_reg(6'h0b, {{32{mem_data[31]}}, mem_data[31:0]});
    // Short float: exponent 0x81 widens to 0x401, fraction moves up
    wr(`RIX_A_MEM_LO, 32'h1234_40c5);
    wr(`RIX_A_INSTR, {6'h20, 5'd4, 5'd10, 16'h0000});
    wr(`RIX_A_RSEL, 32'hffff_ffe4);
    rd_chk(`RIX_A_RSEL, 32'h24);
    chk64(`RIX_A_RDAT_LO, 64'h4018_a246_8000_0000);
    wr(`RIX_A_INSTR, {6'h16, 5'd31, 5'd4, 5'h13, 6'h21, 5'd5});
    rd_chk(`RIX_A_FCTL, 32'h13);
    chk_reg(6'h25, 64'hc018_a246_8000_0000);
    $display("test memory done");
    wr(`RIX_A_INSTR, {`RIX_OP_PRIVILEGED_LIBRARY_CALL, 18'h0, 8'h05});
    chk64(`RIX_A_PC_LO, `RIX_LIB_BASE | 64'h140);
    rd_chk(`RIX_A_LIBFN, 32'h5);
    wr(`RIX_A_CTRL, 32'h0);
    wr(`RIX_A_INSTR, {`RIX_OP_PRIVILEGED_LIBRARY_CALL, 18'h0, 8'h05});
    rd_chk(`RIX_A_STAT, 32'h1);
    wr(`RIX_A_INSTR, {6'h01, 26'h0});
    rd_chk(`RIX_A_STAT, 32'h1);
    wr(`RIX_A_CTRL, 32'h1);
    wr(`RIX_A_INSTR, {6'h01, 26'h0});
    rd_chk(`RIX_A_STAT, 32'h10);
    `CHK(status.halted, 1'b1)
    wr(`RIX_A_PC_LO, 32'h0);
    rd_chk(`RIX_A_PC_LO, 32'h0);
    `CHK(status.halted, 1'b0)
    $display("test privilege done");
    close_out();
  end
endmodule : risc_instruction_semantics_tb_top
`default_nettype wire
